//--- pfc_port_ctrl.sv
/*
  Port pin function control: write-only per-pin direction, function and resistor
  registers on AXI4-Lite, driving registered select lines to the pin multiplexers.
  Assumes one clock, synchronous active-low reset, a master with at most one write
  and one read in flight.
*/
// Behaviour
// - port C pins 7..3 direction: 0 input, 1 output; reset 7,6 out, 5..3 in
// - port B pins 5..0 direction: 0 input, 1 output; reset all inputs
// - port B function bits 5,4,3 route pins to external irq two, one, zero
// - port B pins 5,4 pull up/down select and enable; pins 3..0 pull-up enables
// - port C bit 5 makes serial data pin open-drain when 1, three-state when 0
// - port C pins 5,4 pull up/down select and enable; bit 0 pulls pin 3 up
// - port D function bits select port use or melody, alarm, lcd control outputs
// - port 7 first function bits connect nmi, read strobe, chip selects, timer
// - port 7 second function bits override first function when set
// - port 7 pins 2,0 pull direction; pins 4..0 resistor enables
// - port 6 second function overrides first; bit 3 always written 0
// - port 6 third function bits 5,0 select lcd clocks; bit 1 always 0
// - port 9 function bits enable key-in wakeup per pin; reset 0
// - port 9 pull-up bits enable pull-ups per pin; reset all enabled
// - port 7 pins 4..0 direction: 0 input, 1 output; reset inputs
`timescale 1ns/1ps
`include "pfc_regs.svh"

module pfc_port_ctrl import pfc_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic [7:0] port5_resistor,
  output logic [7:0] port6_dir,
  output logic [7:0] port6_sel_first,
  output logic [7:0] port6_sel_second,
  output logic [7:0] port6_sel_third,
  output logic [4:0] port7_dir,
  output logic [4:0] port7_sel_first,
  output logic [4:0] port7_sel_second,
  output logic [4:0] port7_pu,
  output logic [4:0] port7_pd,
  output logic [7:0] port9_keyin_en,
  output logic [7:0] port9_pu,
  output logic [5:0] portb_dir,
  output logic [2:0] ext_irq_route,
  output logic [5:0] portb_pu,
  output logic [5:0] portb_pd,
  output logic [7:3] portc_dir,
  output logic [7:3] portc_sel_alt,
  output logic serial_out_opendrain_sel,
  output logic [7:3] portc_pu,
  output logic [7:3] portc_pd,
  output logic [7:0] portd_dir,
  output logic [7:0] portd_sel_alt,
  output logic [7:0] portd_pu
);

  localparam int NREG = `PFC_NREG;
  localparam int K_P5R = 0;
  localparam int K_P6D = 1;
  localparam int K_P6F1 = 2;
  localparam int K_P7D = 3;
  localparam int K_P7F1 = 4;
  localparam int K_P6F2 = 5;
  localparam int K_P7F2 = 6;
  localparam int K_P9K = 7;
  localparam int K_P9U = 8;
  localparam int K_P7R = 9;
  localparam int K_PBR = 10;
  localparam int K_PBD = 11;
  localparam int K_PBF = 12;
  localparam int K_PCD = 13;
  localparam int K_PCF = 14;
  localparam int K_PCR = 15;
  localparam int K_PDF = 16;
  localparam int K_PDD = 17;
  localparam int K_PDU = 18;
  localparam int K_P6F3 = 19;

  localparam pfc_byte_t IDX [NREG] = '{
    `PFC_IDX_PORT5_RES, `PFC_IDX_PORT6_DIR, `PFC_IDX_PORT6_FN1, `PFC_IDX_PORT7_DIR,
    `PFC_IDX_PORT7_FN1, `PFC_IDX_PORT6_FN2, `PFC_IDX_PORT7_FN2, `PFC_IDX_PORT9_KEY,
    `PFC_IDX_PORT9_PU, `PFC_IDX_PORT7_RES, `PFC_IDX_PORTB_RES, `PFC_IDX_PORTB_DIR,
    `PFC_IDX_PORTB_FN, `PFC_IDX_PORTC_DIR, `PFC_IDX_PORTC_FN, `PFC_IDX_PORTC_RES,
    `PFC_IDX_PORTD_FN, `PFC_IDX_PORTD_DIR, `PFC_IDX_PORTD_PU, `PFC_IDX_PORT6_FN3};
  localparam pfc_byte_t MSK [NREG] = '{
    `PFC_MSK_PORT5_RES, `PFC_MSK_PORT6_DIR, `PFC_MSK_PORT6_FN1, `PFC_MSK_PORT7_DIR,
    `PFC_MSK_PORT7_FN1, `PFC_MSK_PORT6_FN2, `PFC_MSK_PORT7_FN2, `PFC_MSK_PORT9_KEY,
    `PFC_MSK_PORT9_PU, `PFC_MSK_PORT7_RES, `PFC_MSK_PORTB_RES, `PFC_MSK_PORTB_DIR,
    `PFC_MSK_PORTB_FN, `PFC_MSK_PORTC_DIR, `PFC_MSK_PORTC_FN, `PFC_MSK_PORTC_RES,
    `PFC_MSK_PORTD_FN, `PFC_MSK_PORTD_DIR, `PFC_MSK_PORTD_PU, `PFC_MSK_PORT6_FN3};
  localparam pfc_byte_t RST [NREG] = '{
    `PFC_RST_PORT5_RES, `PFC_RST_PORT6_DIR, `PFC_RST_PORT6_FN1, `PFC_RST_PORT7_DIR,
    `PFC_RST_PORT7_FN1, `PFC_RST_PORT6_FN2, `PFC_RST_PORT7_FN2, `PFC_RST_PORT9_KEY,
    `PFC_RST_PORT9_PU, `PFC_RST_PORT7_RES, `PFC_RST_PORTB_RES, `PFC_RST_PORTB_DIR,
    `PFC_RST_PORTB_FN, `PFC_RST_PORTC_DIR, `PFC_RST_PORTC_FN, `PFC_RST_PORTC_RES,
    `PFC_RST_PORTD_FN, `PFC_RST_PORTD_DIR, `PFC_RST_PORTD_PU, `PFC_RST_PORT6_FN3};

  // bus channel state
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  pfc_byte_t wdata_q;
  logic wstrb0_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  pfc_resp_t bresp_q;
  logic arready_q;
  logic rvalid_q;
  pfc_resp_t rresp_q;
  logic [31:0] rdata_q;

  wire aw_take = awvalid & awready_q;
  wire w_take = wvalid & wready_q;
  wire ar_take = arvalid & arready_q;
  wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire aw_held_d = (aw_held_q | aw_take) & ~wr_fire;
  wire w_held_d = (w_held_q | w_take) & ~wr_fire;
  wire bvalid_d = wr_fire | (bvalid_q & ~bready);
  wire rvalid_d = ar_take | (rvalid_q & ~rready);

  // address decode against word indices
  wire wr_upper_ok = (awaddr_q >> (`PFC_ADDR_LSB + 8)) == '0;
  wire rd_upper_ok = (araddr >> (`PFC_ADDR_LSB + 8)) == '0;
  wire [7:0] wr_word = awaddr_q[`PFC_ADDR_LSB +: 8];
  wire [7:0] rd_word = araddr[`PFC_ADDR_LSB +: 8];
  logic [NREG-1:0] wr_hit;
  logic [NREG-1:0] rd_hit;
  pfc_byte_t ctl_q [NREG];
  pfc_byte_t ctl_d [NREG];

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign wr_hit[g] = wr_upper_ok & (wr_word == IDX[g]);
      assign rd_hit[g] = rd_upper_ok & (rd_word == IDX[g]);
      // byte lane 0 only; unassigned bits stay at zero
      assign ctl_d[g] = (wr_fire & wr_hit[g] & wstrb0_q) ? (wdata_q & MSK[g]) : ctl_q[g];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctl_q[g] <= RST[g];
        end else begin
          ctl_q[g] <= ctl_d[g];
        end
      end
    end
  endgenerate

  wire wr_any = |wr_hit;
  wire rd_any = |rd_hit;

  // select and resistor decode from next register values, so pins follow the write edge
  wire [7:0] p6_second_d = ctl_d[K_P6F2] & ~ctl_d[K_P6F3];
  wire [7:0] p6_first_d = ctl_d[K_P6F1] & ~ctl_d[K_P6F2] & ~ctl_d[K_P6F3];
  wire [4:0] p7_second_d = ctl_d[K_P7F2][4:0];
  wire [4:0] p7_first_d = ctl_d[K_P7F1][4:0] & ~ctl_d[K_P7F2][4:0];
  wire [7:0] p7r = ctl_d[K_P7R];
  wire [4:0] p7_en_d = {p7r[4], p7r[3], p7r[6], p7r[1], p7r[0]};
  wire [4:0] p7_dn_d = {2'b00, p7r[5], 1'b0, p7r[2]};
  wire [7:0] pbr = ctl_d[K_PBR];
  wire [5:0] pb_pu_d = {pbr[5] & ~pbr[7], pbr[4] & ~pbr[6], pbr[3:0]};
  wire [5:0] pb_pd_d = {pbr[5] & pbr[7], pbr[4] & pbr[6], 4'h0};
  wire [7:0] pcr = ctl_d[K_PCR];
  wire [7:3] pc_pu_d = {2'b00, pcr[2] & ~pcr[4], pcr[1] & ~pcr[3], pcr[0]};
  wire [7:3] pc_pd_d = {2'b00, pcr[2] & pcr[4], pcr[1] & pcr[3], 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port6_sel_first <= 8'h00;
      port6_sel_second <= 8'h00;
      port6_sel_third <= 8'h00;
      port7_sel_first <= 5'h00;
      port7_sel_second <= 5'h00;
      port7_pu <= `PFC_RST_PORT7_PU;
      port7_pd <= 5'h00;
      portb_pu <= `PFC_RST_PORTB_PU;
      portb_pd <= 6'h00;
      portc_pu <= 5'h00;
      portc_pd <= 5'h00;
    end else begin
      port6_sel_first <= p6_first_d;
      port6_sel_second <= p6_second_d;
      port6_sel_third <= ctl_d[K_P6F3];
      port7_sel_first <= p7_first_d;
      port7_sel_second <= p7_second_d;
      port7_pu <= p7_en_d & ~p7_dn_d;
      port7_pd <= p7_en_d & p7_dn_d;
      portb_pu <= pb_pu_d;
      portb_pd <= pb_pd_d;
      portc_pu <= pc_pu_d;
      portc_pd <= pc_pd_d;
    end
  end

  // raw register fields straight out
  assign port5_resistor = ctl_q[K_P5R];
  assign port6_dir = ctl_q[K_P6D];
  assign port7_dir = ctl_q[K_P7D][4:0];
  assign port9_keyin_en = ctl_q[K_P9K];
  assign port9_pu = ctl_q[K_P9U];
  assign portb_dir = ctl_q[K_PBD][5:0];
  assign ext_irq_route = ctl_q[K_PBF][5:3];
  assign portc_dir = ctl_q[K_PCD][7:3];
  assign portc_sel_alt = ctl_q[K_PCF][7:3];
  assign serial_out_opendrain_sel = ctl_q[K_PCR][5];
  assign portd_dir = ctl_q[K_PDD];
  assign portd_sel_alt = ctl_q[K_PDF];
  assign portd_pu = ctl_q[K_PDU];

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `PFC_RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= ~aw_held_d;
      wready_q <= ~w_held_d;
      bvalid_q <= bvalid_d;
      if (aw_take) begin
        awaddr_q <= awaddr;
      end
      if (w_take) begin
        wdata_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (wr_fire) begin
        bresp_q <= wr_any ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
      end
    end
  end

  // read channel; registers are write-only and read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `PFC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rresp_q <= rd_any ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_unmapped_write_err: assert property (wr_fire && !wr_any |=> bvalid && bresp == `PFC_RESP_SLVERR)
    else $error("unmapped write not answered with slverr");
  a_port7_dir_write: assert property (
    wr_fire && wr_hit[K_P7D] && wstrb0_q |=> port7_dir == $past(wdata_q[4:0]))
    else $error("port 7 direction not updated at write edge");
  a_portb_dir_write: assert property (
    wr_fire && wr_hit[K_PBD] && wstrb0_q |=> portb_dir == $past(wdata_q[5:0]))
    else $error("port b direction not updated at write edge");
  a_portc_dir_reset: assert property ($past(!aresetn) |-> portc_dir == RST[K_PCD][7:3])
    else $error("port c direction wrong after reset");
  a_irq_route_write: assert property (
    wr_fire && wr_hit[K_PBF] && wstrb0_q |=> ext_irq_route == $past(wdata_q[5:3]))
    else $error("external irq routing not updated");
  a_pull_exclusive: assert property (
    (portb_pu & portb_pd) == 6'h00 && (portc_pu & portc_pd) == 5'h00
    && (port7_pu & port7_pd) == 5'h00)
    else $error("pull-up and pull-down on together");
  a_opendrain_write: assert property (
    wr_fire && wr_hit[K_PCR] && wstrb0_q |=> serial_out_opendrain_sel == $past(wdata_q[5]))
    else $error("serial output mode not updated");
  a_port7_second_wins: assert property (
    (port7_sel_first & port7_sel_second) == 5'h00)
    else $error("port 7 first and second function both selected");
  a_port6_reserved: assert property (
    port6_sel_second[3] == 1'b0 && port6_sel_third[1] == 1'b0)
    else $error("port 6 reserved function bit reached a pin");
  a_portd_reserved: assert property (
    portd_sel_alt[5] == 1'b0 && portd_pu[5] == 1'b0)
    else $error("port d unassigned bit active");
  a_port9_pu_write: assert property (
    wr_fire && wr_hit[K_P9U] && wstrb0_q |=> port9_pu == $past(wdata_q))
    else $error("port 9 pull-ups not updated");
  a_port9_key_write: assert property (
    wr_fire && wr_hit[K_P9K] && wstrb0_q |=> port9_keyin_en == $past(wdata_q))
    else $error("port 9 key-in enables not updated");
  a_read_zero: assert property (ar_take |=> rvalid && rdata == 32'h0000_0000)
    else $error("read answer missing or not zero");

endmodule

//--- pfc_regs.svh
/*
  Register map constants for the port pin function control block.
  Assumes word-aligned 32-bit AXI4-Lite access; byte address is four times the index.
*/
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

`define PFC_NREG 20
`define PFC_ADDR_LSB 2

`define PFC_IDX_PORT5_RES 8'h0e
`define PFC_IDX_PORT6_DIR 8'h14
`define PFC_IDX_PORT6_FN1 8'h15
`define PFC_IDX_PORT7_DIR 8'h16
`define PFC_IDX_PORT7_FN1 8'h17
`define PFC_IDX_PORT6_FN2 8'h1b
`define PFC_IDX_PORT7_FN2 8'h1c
`define PFC_IDX_PORT9_KEY 8'h1d
`define PFC_IDX_PORT9_PU 8'h1e
`define PFC_IDX_PORT7_RES 8'h1f
`define PFC_IDX_PORTB_RES 8'h20
`define PFC_IDX_PORTB_DIR 8'h24
`define PFC_IDX_PORTB_FN 8'h25
`define PFC_IDX_PORTC_DIR 8'h26
`define PFC_IDX_PORTC_FN 8'h27
`define PFC_IDX_PORTC_RES 8'h28
`define PFC_IDX_PORTD_FN 8'h2a
`define PFC_IDX_PORTD_DIR 8'h2b
`define PFC_IDX_PORTD_PU 8'h2c
`define PFC_IDX_PORT6_FN3 8'h31

`define PFC_MSK_PORT5_RES 8'h4f
`define PFC_MSK_PORT6_DIR 8'hff
`define PFC_MSK_PORT6_FN1 8'hff
`define PFC_MSK_PORT7_DIR 8'h1f
`define PFC_MSK_PORT7_FN1 8'h1f
`define PFC_MSK_PORT6_FN2 8'hf4
`define PFC_MSK_PORT7_FN2 8'h1b
`define PFC_MSK_PORT9_KEY 8'hff
`define PFC_MSK_PORT9_PU 8'hff
`define PFC_MSK_PORT7_RES 8'h7f
`define PFC_MSK_PORTB_RES 8'hff
`define PFC_MSK_PORTB_DIR 8'h3f
`define PFC_MSK_PORTB_FN 8'h38
`define PFC_MSK_PORTC_DIR 8'hf8
`define PFC_MSK_PORTC_FN 8'h28
`define PFC_MSK_PORTC_RES 8'h3f
`define PFC_MSK_PORTD_FN 8'hdf
`define PFC_MSK_PORTD_DIR 8'hdf
`define PFC_MSK_PORTD_PU 8'hdf
`define PFC_MSK_PORT6_FN3 8'h21

`define PFC_RST_PORT5_RES 8'h4e
`define PFC_RST_PORT6_DIR 8'h00
`define PFC_RST_PORT6_FN1 8'h00
`define PFC_RST_PORT7_DIR 8'h00
`define PFC_RST_PORT7_FN1 8'h00
`define PFC_RST_PORT6_FN2 8'h00
`define PFC_RST_PORT7_FN2 8'h00
`define PFC_RST_PORT9_KEY 8'h00
`define PFC_RST_PORT9_PU 8'hff
`define PFC_RST_PORT7_RES 8'h08
`define PFC_RST_PORTB_RES 8'h08
`define PFC_RST_PORTB_DIR 8'h00
`define PFC_RST_PORTB_FN 8'h00
`define PFC_RST_PORTC_DIR 8'hc0
`define PFC_RST_PORTC_FN 8'h00
`define PFC_RST_PORTC_RES 8'h00
`define PFC_RST_PORTD_FN 8'h00
`define PFC_RST_PORTD_DIR 8'h00
`define PFC_RST_PORTD_PU 8'h1f
`define PFC_RST_PORT6_FN3 8'h00

`define PFC_RST_PORT7_PU 5'h08
`define PFC_RST_PORTB_PU 6'h08

`define PFC_RESP_OKAY 2'h0
`define PFC_RESP_SLVERR 2'h2

`endif

//--- pfc_pkg.sv
/*
  Types shared by the port pin function control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pfc_pkg;
  typedef logic [7:0] pfc_byte_t;
  typedef logic [1:0] pfc_resp_t;
endpackage

//--- pfc_pin_model.sv
/*
  Pin-side model of the port 9 pads: reports the level seen on each pad.
  Assumes the pads are otherwise undriven; a pad without pull-up floats.
*/
`timescale 1ns/1ps
module pfc_pin_model (
  input wire logic aclk,
  input wire logic [7:0] port9_pu,
  output logic [7:0] pin_level
);
  logic [7:0] drift_q = 8'h5a;
  // floating pads wander every cycle
  always_ff @(posedge aclk) begin
    drift_q <= ~drift_q;
  end
  assign pin_level = port9_pu | (~port9_pu & drift_q);
endmodule

//--- pfc_port_ctrl_tb_top.sv
/*
  Self-checking bench for the port pin function control block.
  Assumes an AXI4-Lite slave with registered handshakes and registered outputs.
*/
`timescale 1ns/1ps
`include "pfc_regs.svh"
module pfc_port_ctrl_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, serial_out_opendrain_sel;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] port5_resistor, port6_dir, port6_sel_first, port6_sel_second, port6_sel_third;
  logic [4:0] port7_dir, port7_sel_first, port7_sel_second, port7_pu, port7_pd;
  logic [7:0] port9_keyin_en, port9_pu, portd_dir, portd_sel_alt, portd_pu, pin_level;
  logic [5:0] portb_dir, portb_pu, portb_pd;
  logic [2:0] ext_irq_route;
  logic [7:3] portc_dir, portc_sel_alt, portc_pu, portc_pd;
  int n_fail = 0;
  int num_checks = 0;

  always #2.5 aclk = ~aclk;

  pfc_port_ctrl #(.ADDR_W(12)) pfc_port_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .port5_resistor(port5_resistor), .port6_dir(port6_dir),
    .port6_sel_first(port6_sel_first), .port6_sel_second(port6_sel_second),
    .port6_sel_third(port6_sel_third), .port7_dir(port7_dir),
    .port7_sel_first(port7_sel_first), .port7_sel_second(port7_sel_second),
    .port7_pu(port7_pu), .port7_pd(port7_pd), .port9_keyin_en(port9_keyin_en),
    .port9_pu(port9_pu), .portb_dir(portb_dir), .ext_irq_route(ext_irq_route),
    .portb_pu(portb_pu), .portb_pd(portb_pd), .portc_dir(portc_dir),
    .portc_sel_alt(portc_sel_alt), .serial_out_opendrain_sel(serial_out_opendrain_sel),
    .portc_pu(portc_pu), .portc_pd(portc_pd), .portd_dir(portd_dir),
    .portd_sel_alt(portd_sel_alt), .portd_pu(portd_pu));

  pfc_pin_model pfc_pin_model_inst (.aclk(aclk), .port9_pu(port9_pu), .pin_level(pin_level));

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_fail++;
    $display("Error at %0t: bus handshake timed out", $time);
    wrap_up();
  endtask

  // one write; releases each channel once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
        break;
    end
    if (i == 40)
      hang();
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] idx, input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
        break;
    end
    if (i == 40)
      hang();
    rready <= 1'b0;
    chk(32'(rresp), 32'(er));
    chk(rdata, 32'h0);
  endtask

  task automatic t_reset();
    chk(32'(portc_dir), 32'h18);
    chk(32'(portb_dir), 32'h0);
    chk(32'(ext_irq_route), 32'h0);
    chk(32'(portb_pu), 32'h08);
    chk(32'(serial_out_opendrain_sel), 32'h0);
    chk(32'(portd_sel_alt), 32'h0);
    chk(32'(portd_pu), 32'h1f);
    chk(32'(port7_sel_first), 32'h0);
    chk(32'(port9_keyin_en), 32'h0);
    chk(32'(port9_pu), 32'hff);
    chk(32'(pin_level), 32'hff);
    chk(32'(port7_dir), 32'h0);
    chk(32'(port6_dir), 32'(`PFC_RST_PORT6_DIR));
  endtask

  task automatic t_dir();
    wr(`PFC_IDX_PORTC_DIR, 8'h38, 4'h1, `PFC_RESP_OKAY);
    chk(32'(portc_dir), 32'h07);
    wr(`PFC_IDX_PORTB_DIR, 8'hff, 4'h1, `PFC_RESP_OKAY);
    chk(32'(portb_dir), 32'h3f);
    wr(`PFC_IDX_PORT7_DIR, 8'hea, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port7_dir), 32'h0a);
    wr(`PFC_IDX_PORTD_DIR, 8'hff, 4'h1, `PFC_RESP_OKAY);
    chk(32'(portd_dir), 32'hdf);
    wr(`PFC_IDX_PORT6_DIR, 8'ha5, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port6_dir), 32'ha5);
    wr(`PFC_IDX_PORT5_RES, 8'hff, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port5_resistor), 32'h4f);
  endtask

  task automatic t_func();
    wr(`PFC_IDX_PORTB_FN, 8'hff, 4'h1, `PFC_RESP_OKAY);
    chk(32'(ext_irq_route), 32'h7);
    wr(`PFC_IDX_PORTD_FN, 8'hff, 4'h1, `PFC_RESP_OKAY);
    chk(32'(portd_sel_alt), 32'hdf);
    wr(`PFC_IDX_PORTC_FN, 8'hff, 4'h1, `PFC_RESP_OKAY);
    chk(32'(portc_sel_alt), 32'h05);
    wr(`PFC_IDX_PORT7_FN1, 8'h1f, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port7_sel_first), 32'h1f);
    wr(`PFC_IDX_PORT7_FN2, 8'hff, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port7_sel_second), 32'h1b);
    chk(32'(port7_sel_first), 32'h04);
    wr(`PFC_IDX_PORT9_KEY, 8'ha5, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port9_keyin_en), 32'ha5);
    wr(`PFC_IDX_PORT9_PU, 8'h3c, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port9_pu), 32'h3c);
    wr(`PFC_IDX_PORTD_PU, 8'hdf, 4'h1, `PFC_RESP_OKAY);
    chk(32'(portd_pu), 32'hdf);
  endtask

  task automatic t_res();
    wr(`PFC_IDX_PORTB_RES, 8'hf6, 4'h1, `PFC_RESP_OKAY);
    chk(32'(portb_pd), 32'h30);
    chk(32'(portb_pu), 32'h06);
    wr(`PFC_IDX_PORTC_RES, 8'h3f, 4'h1, `PFC_RESP_OKAY);
    chk(32'(serial_out_opendrain_sel), 32'h1);
    chk(32'(portc_pd), 32'h06);
    chk(32'(portc_pu), 32'h01);
    wr(`PFC_IDX_PORT7_RES, 8'h7f, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port7_pd), 32'h05);
    chk(32'(port7_pu), 32'h1a);
  endtask

  task automatic t_port6();
    wr(`PFC_IDX_PORT6_FN1, 8'hff, 4'h1, `PFC_RESP_OKAY);
    wr(`PFC_IDX_PORT6_FN2, 8'hf7, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port6_sel_second), 32'hf4);
    chk(32'(port6_sel_first), 32'h0b);
    wr(`PFC_IDX_PORT6_FN3, 8'hfd, 4'h1, `PFC_RESP_OKAY);
    chk(32'(port6_sel_third), 32'h21);
    chk(32'(port6_sel_second), 32'hd4);
  endtask

  task automatic t_bus();
    wr(`PFC_IDX_PORTB_DIR, 8'h00, 4'h0, `PFC_RESP_OKAY);
    chk(32'(portb_dir), 32'h3f);
    wr(8'h00, 8'hff, 4'h1, `PFC_RESP_SLVERR);
    chk(32'(portb_dir), 32'h3f);
    rd(`PFC_IDX_PORT9_PU, `PFC_RESP_OKAY);
    rd(8'h01, `PFC_RESP_SLVERR);
  endtask

  // reset in mid-run must bring written registers back
  task automatic t_rerun();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_dir();
    t_func();
    t_res();
    t_port6();
    t_bus();
    t_rerun();
    repeat (3) @(posedge aclk);
    wrap_up();
  end
endmodule
